// ==== mer_pkg.sv ====
// Package of constants for the exception responder
package mer_pkg;
	localparam logic [7:0] FC_ERR_BIT = 8'h80;
	localparam logic [7:0] CAUSE_ILL_FUNC = 8'h01;
	localparam logic [7:0] CAUSE_ILL_ADDR = 8'h02;
	localparam logic [7:0] CAUSE_ILL_VALUE = 8'h03;
	localparam logic [7:0] CAUSE_CHECK = 8'h11;
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;
	localparam int CLK_HZ = 20_000_000;
	localparam int GAP_TENTHS_CHAR = 35;
	typedef enum {MER_IDLE, MER_GAP_PRE, MER_ADDR, MER_FUNC, MER_CAUSE, MER_CRC_LO,
		MER_CRC_HI, MER_GAP_POST} mer_state_e;
endpackage

// ==== mer_responder.sv ====
// Exception responder: picks normal or exception reply and emits exception frames
// Function
// - Normal reply echoes the request function code
// - Exception reply sets function code top bit
// - Exception reply adds exactly one cause byte
// - Cause 01H for unsupported or forbidden function
// - Cause 01H allowed while slave is faulted
// - Cause 02H for bad address or quantity
// - Cause 03H for out-of-range value, no write
// - Cause 11H when frame check mismatches
// - Binary frames end with two-byte CRC
// - CRC preset FFFF, data bits only
// - Frames surrounded by 3.5 character idle gaps
module mer_responder
	import mer_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_req_valid,
	input wire logic [7:0] i_slave_addr,
	input wire logic [7:0] i_req_func,
	input wire logic i_func_unsupported,
	input wire logic i_slave_fault,
	input wire logic i_addr_illegal,
	input wire logic i_value_illegal,
	input wire logic i_check_bad,
	input wire logic i_char_tick,
	input wire logic i_tx_ready,
	output logic o_busy,
	output logic o_normal,
	output logic [7:0] o_reply_func,
	output logic o_write_allow,
	output logic o_tx_valid,
	output logic [7:0] o_tx_byte,
	output logic o_tx_last
);
	localparam logic [5:0] GAP_HALVES = 6'(((GAP_TENTHS_CHAR * 2) + 9) / 10);
	mer_state_e state_q;
	logic [7:0] addr_q;
	logic [7:0] func_q;
	logic [7:0] cause_q;
	logic [15:0] crc_q;
	logic [5:0] gap_q;
	logic normal_q;
	logic half_q;
	logic [7:0] reply_q;
	// Cause priority: a broken check makes the rest of the frame untrustworthy
	wire exc_check = i_check_bad;
	wire exc_func = i_func_unsupported | i_slave_fault;
	wire exc_any = exc_check | exc_func | i_addr_illegal | i_value_illegal;
	wire [7:0] cause_d = exc_check ? CAUSE_CHECK :
		exc_func ? CAUSE_ILL_FUNC :
		i_addr_illegal ? CAUSE_ILL_ADDR :
		CAUSE_ILL_VALUE;
	wire take = i_req_valid && (state_q == MER_IDLE);
	wire send_st = (state_q == MER_ADDR) || (state_q == MER_FUNC) || (state_q == MER_CAUSE) ||
		(state_q == MER_CRC_LO) || (state_q == MER_CRC_HI);
	wire beat = send_st && i_tx_ready;
	wire crc_feed = beat && (state_q != MER_CRC_LO) && (state_q != MER_CRC_HI);
	// Only the eight data bits enter the CRC
	logic [15:0] crc_nx;
	always_comb begin
		crc_nx = crc_q ^ {8'h00, o_tx_byte};
		for (int i = 0; i < 8; i++) begin
			crc_nx = crc_nx[0] ? ((crc_nx >> 1) ^ CRC_POLY) : (crc_nx >> 1);
		end
	end
	// Gap counted in half characters so 3.5 rounds up exactly
	wire half_tick = i_char_tick | half_q;
	wire gap_done = (gap_q >= GAP_HALVES);
	always_comb begin
		case (state_q)
			MER_ADDR: o_tx_byte = addr_q;
			MER_FUNC: o_tx_byte = func_q | FC_ERR_BIT;
			MER_CAUSE: o_tx_byte = cause_q;
			MER_CRC_LO: o_tx_byte = crc_q[7:0];
			MER_CRC_HI: o_tx_byte = crc_q[15:8];
			default: o_tx_byte = 8'h00;
		endcase
	end
	assign o_tx_valid = send_st;
	assign o_tx_last = (state_q == MER_CRC_HI);
	assign o_busy = (state_q != MER_IDLE);
	assign o_normal = normal_q;
	// Reply code comes from a flop so the framer sees no glitch while it builds the reply
	assign o_reply_func = reply_q;
	// Parameter write only when no exception; the framer must gate on this
	assign o_write_allow = take && !exc_any;
	// A char tick counts twice, on its own cycle and on the next
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			half_q <= 1'b0;
		end else begin
			half_q <= i_char_tick;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_q <= 8'h00;
			func_q <= 8'h00;
			cause_q <= 8'h00;
			normal_q <= 1'b0;
			reply_q <= FC_ERR_BIT;
		end else if (take) begin
			addr_q <= i_slave_addr;
			func_q <= i_req_func;
			cause_q <= cause_d;
			normal_q <= !exc_any;
			reply_q <= exc_any ? (i_req_func | FC_ERR_BIT) : i_req_func;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc_q <= CRC_PRESET;
		end else if (take) begin
			crc_q <= CRC_PRESET;
		end else if (crc_feed) begin
			crc_q <= crc_nx;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			gap_q <= 6'h00;
		end else if ((state_q != MER_GAP_PRE) && (state_q != MER_GAP_POST)) begin
			gap_q <= 6'h00;
		end else if (half_tick && !gap_done) begin
			gap_q <= gap_q + 6'h01;
		end
	end
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= MER_IDLE;
		end else begin
			case (state_q)
				MER_IDLE: if (take && exc_any) state_q <= MER_GAP_PRE;
				MER_GAP_PRE: if (gap_done) state_q <= MER_ADDR;
				MER_ADDR: if (beat) state_q <= MER_FUNC;
				MER_FUNC: if (beat) state_q <= MER_CAUSE;
				MER_CAUSE: if (beat) state_q <= MER_CRC_LO;
				MER_CRC_LO: if (beat) state_q <= MER_CRC_HI;
				MER_CRC_HI: if (beat) state_q <= MER_GAP_POST;
				MER_GAP_POST: if (gap_done) state_q <= MER_IDLE;
				default: state_q <= MER_IDLE;
			endcase
		end
	end
	sequence s_exc_req;
		take && exc_any;
	endsequence
	sequence s_check_req;
		take && i_check_bad;
	endsequence
	norm_echo_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && !exc_any |=> o_normal && (o_reply_func == $past(i_req_func)))
		else $error("normal reply code not echoed");
	exc_topbit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_exc_req |=> !o_normal && (o_reply_func == ($past(i_req_func) | 8'h80)))
		else $error("exception code top bit missing");
	one_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		beat && state_q == MER_CAUSE |=> state_q == MER_CRC_LO)
		else $error("cause not followed by crc");
	func_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && !i_check_bad && i_func_unsupported |=> cause_q == 8'h01)
		else $error("illegal function cause wrong");
	fault_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && !i_check_bad && i_slave_fault |=> cause_q == 8'h01)
		else $error("fault cause wrong");
	addr_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && !i_check_bad && !exc_func && i_addr_illegal |=> cause_q == 8'h02)
		else $error("address cause wrong");
	value_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_value_illegal |-> !o_write_allow)
		else $error("illegal value allowed to write");
	check_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_check_req |=> cause_q == 8'h11 ##0 (!o_tx_valid)[*7])
		else $error("check cause wrong or gap short");
	crc_preset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take |=> crc_q == 16'hFFFF)
		else $error("crc not preset");
	frame_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_q == MER_ADDR && beat |-> o_tx_byte == addr_q)
		else $error("frame does not start with address");
	// Stall and end-of-frame steps, named so the properties read as the frame walk
	sequence s_stall;
		o_tx_valid && !i_tx_ready;
	endsequence
	sequence s_last_beat;
		o_tx_last && i_tx_ready;
	endsequence
	// Frame bytes must not move while the master stalls
	tx_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_stall |=> o_tx_valid && $stable(o_tx_byte))
		else $error("tx byte changed under stall");
	post_gap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_last_beat |=> (o_busy && !o_tx_valid)[*7])
		else $error("post frame gap short");
	frame_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_last_beat |=> state_q == MER_GAP_POST)
		else $error("frame runs past crc high byte");
	normal_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && !exc_any |=> !o_busy)
		else $error("normal reply made block busy");
	exc_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		s_exc_req |=> o_busy)
		else $error("exception did not start frame");
	write_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_busy |-> !o_write_allow)
		else $error("write allowed while busy");
	// Lowest cause only when nothing ranks above it
	value_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		take && !i_check_bad && !exc_func && !i_addr_illegal && i_value_illegal |=>
		cause_q == 8'h03)
		else $error("value cause wrong");
	tx_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!o_busy |-> !o_tx_valid)
		else $error("tx valid outside frame");
	cause_byte_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		state_q == MER_CAUSE |-> o_tx_byte == cause_q)
		else $error("cause byte not sent");
	refuse_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		o_busy && i_req_valid |=> $stable(o_reply_func))
		else $error("busy request changed reply code");
endmodule

// ==== mer_master_model.sv ====
// Master-side model that takes exception frame bytes, promptly or with stalls
module mer_master_model (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire logic i_tx_valid,
	input wire logic i_tx_last,
	input wire logic [7:0] i_tx_byte,
	output logic o_tx_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	// Each entry keeps the last flag above the byte so framing is checked too
	logic [8:0] got[$];
	logic ph;
	// Slow mode refuses every other cycle so each byte must hold under a stall
	initial begin
		ph = 1'b0;
		o_tx_ready = 1'b0;
		forever begin
			@(negedge i_clk);
			ph <= ~ph;
			o_tx_ready <= !i_slow || ph;
		end
	end
	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready) begin
			got.push_back({i_tx_last, i_tx_byte});
		end
	end
endmodule

// ==== mer_responder_tb.sv ====
// Self-checking bench for the exception responder
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("CHECK FAILED at %0t: value mismatch", $time); end end
module mer_responder_tb;
	import mer_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk, i_rst_n, i_req_valid, i_char_tick, i_tx_ready, slow;
	logic [7:0] i_req_func, o_reply_func, o_tx_byte, slave_addr;
	logic [4:0] fl;
	logic [1:0] tcnt = 2'd0;
	logic o_busy, o_normal, o_write_allow, o_tx_valid, o_tx_last;
	int mismatches = 0;
	int samples_checked = 0;
	mer_responder u_mer_responder (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
		.i_slave_addr(slave_addr), .i_req_func(i_req_func), .i_func_unsupported(fl[4]),
		.i_slave_fault(fl[3]), .i_addr_illegal(fl[2]), .i_value_illegal(fl[1]),
		.i_check_bad(fl[0]), .i_char_tick(i_char_tick), .i_tx_ready(i_tx_ready),
		.o_busy(o_busy), .o_normal(o_normal), .o_reply_func(o_reply_func),
		.o_write_allow(o_write_allow), .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte),
		.o_tx_last(o_tx_last));
	mer_master_model u_mer_master_model (.i_clk(i_clk), .i_slow(slow), .i_tx_valid(o_tx_valid),
		.i_tx_last(o_tx_last), .i_tx_byte(o_tx_byte), .o_tx_ready(i_tx_ready));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// One character time every four clocks keeps the idle gaps short
	initial begin
		i_char_tick = 1'b0;
		forever begin
			@(negedge i_clk);
			tcnt <= tcnt + 2'd1;
			i_char_tick <= &tcnt;
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic req(input logic [7:0] f, input logic [4:0] flags);
		@(negedge i_clk);
		i_req_func = f;
		fl = flags;
		i_req_valid = 1'b1;
		#1 `CHK(o_write_allow, flags == 5'd0)
		@(negedge i_clk);
		i_req_valid = 1'b0;
		fl = 5'd0;
	endtask
	task automatic t_norm(input logic [7:0] f);
		req(f, 5'd0);
		`CHK(o_normal, 1'b1)
		`CHK(o_reply_func, f)
		`CHK(o_busy, 1'b0)
		$display("normal reply test done");
	endtask
	task automatic t_reset();
		req(8'h05, 5'b10000);
		repeat (3) @(negedge i_clk);
		i_rst_n = 1'b0;
		@(negedge i_clk);
		`CHK(o_busy, 1'b0)
		`CHK(o_tx_valid, 1'b0)
		`CHK(o_reply_func, FC_ERR_BIT)
		`CHK(o_normal, 1'b0)
		@(negedge i_clk);
		i_rst_n = 1'b1;
		req(8'h04, 5'd0);
		`CHK(o_normal, 1'b1)
		`CHK(o_reply_func, 8'h04)
		`CHK(o_busy, 1'b0)
		$display("reset recovery test done");
	endtask
	task automatic t_exc(input logic [7:0] f, input logic [4:0] flags, input logic [7:0] c,
		input logic s);
		logic [7:0] e[5];
		logic [15:0] crc;
		int n;
		slow = s;
		slave_addr = ~f;
		u_mer_master_model.got.delete();
		req(f, flags);
		`CHK(o_normal, 1'b0)
		`CHK(o_reply_func, f | FC_ERR_BIT)
		repeat (5) @(negedge i_clk);
		`CHK(o_tx_valid, 1'b0)
		// Offered while busy, this normal request must leave no trace
		i_req_func = 8'h01;
		slave_addr = f;
		i_req_valid = 1'b1;
		#1 `CHK(o_write_allow, 1'b0)
		@(negedge i_clk);
		i_req_valid = 1'b0;
		n = 0;
		while (o_busy === 1'b1 && n < 2000) begin
			@(negedge i_clk);
			n++;
		end
		`CHK(o_busy, 1'b0)
		`CHK(o_reply_func, f | FC_ERR_BIT)
		e = '{~f, f | FC_ERR_BIT, c, 8'h00, 8'h00};
		crc = CRC_PRESET;
		for (int i = 0; i < 3; i++) begin
			crc = crc ^ {8'h00, e[i]};
			for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
		end
		e[3] = crc[7:0];
		e[4] = crc[15:8];
		`CHK(u_mer_master_model.got.size() == 5, 1'b1)
		for (int i = 0; i < 5 && i < u_mer_master_model.got.size(); i++)
			`CHK(u_mer_master_model.got[i], {i == 4, e[i]})
		$display("exception frame test done");
	endtask
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		close_out();
	end
	initial begin
		{i_rst_n, i_req_valid, slow, fl, i_req_func, slave_addr} = '0;
		repeat (12) @(negedge i_clk);
		`CHK(o_reply_func, FC_ERR_BIT)
		i_rst_n = 1'b1;
		t_norm(8'h03);
		t_norm(8'h10);
		t_exc(8'h03, 5'b00001, CAUSE_CHECK, 1'b0);
		t_norm(8'h03);
		t_exc(8'h2B, 5'b10000, CAUSE_ILL_FUNC, 1'b1);
		t_exc(8'h06, 5'b01000, CAUSE_ILL_FUNC, 1'b0);
		t_exc(8'h03, 5'b00100, CAUSE_ILL_ADDR, 1'b1);
		t_exc(8'h10, 5'b00010, CAUSE_ILL_VALUE, 1'b0);
		t_exc(8'h06, 5'b00110, CAUSE_ILL_ADDR, 1'b1);
		t_exc(8'h03, 5'b11111, CAUSE_CHECK, 1'b0);
		t_reset();
		close_out();
	end
endmodule
